// *** verification/annp_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Negotiation engine stand-in
module annp_partner
(
   // Clock
   input wire logic clk,
   // Engine side
   output logic stb,
   output logic [15:0] word,
   output logic tog,
   output logic fault,
   output logic np_cap,
   output logic an_cap
);
   initial
   begin
      stb = 1'b0;
      word = 16'h0000;
      tog = 1'b0;
      fault = 1'b0;
      np_cap = 1'b0;
      an_cap = 1'b0;
   end

   // One-cycle page strobe; word lines scrambled once released
   task automatic send(input logic [15:0] w, input logic t);
      @(posedge clk);
      stb <= 1'b1;
      word <= w;
      tog <= t;
      @(posedge clk);
      stb <= 1'b0;
      word <= ~w;
      tog <= ~t;
   endtask

   task automatic levels(input logic f, input logic n, input logic a);
      fault <= f;
      np_cap <= n;
      an_cap <= a;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// *** verification/annp_status_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "annp_map.svh"
module annp_status_regs_bench
   import annp_pkg::*;
;
   localparam logic [31:0] A_NPW = {22'h0, `ANNP_IDX_NPW, 2'b00};
   localparam logic [31:0] A_EXP = {22'h0, `ANNP_IDX_EXP, 2'b00};
   localparam logic [31:0] A_IST = {22'h0, `ANNP_IDX_IST, 2'b00};
   localparam logic [31:0] A_MSK = {22'h0, `ANNP_IDX_IMSK, 2'b00};
   logic clk, rst, hwrite, hready, hresp, irq, stb, tog, fault, npc, anc;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [15:0] word;
   int bad_count = 0;
   int compares = 0;

   annp_status_regs dut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .page_rx_stb(stb), .page_rx_word(word), .tx_toggle_prev(tog),
      .parallel_detect_fault(fault), .partner_nextpage_capable(npc),
      .partner_autoneg_capable(anc), .irq(irq));
   annp_partner pm (.clk(clk), .stb(stb), .word(word), .tog(tog),
      .fault(fault), .np_cap(npc), .an_cap(anc));

   // ==========================================================
   // Bus and check tasks
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e || hresp !== 1'b0)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            bad_count++;
            close_out();
         end
         @(posedge clk);
      end
   endtask

   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(hrdata, e);
   endtask

   task automatic chk_irq(input logic e);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, e});
      @(posedge clk);
   endtask

   function automatic logic [31:0] npw(input logic [15:0] w, input logic t);
      return {16'h0, w[15:12], ~t, w[10:0]};
   endfunction

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      rst = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(A_NPW, 32'h0);
      rd(A_EXP, 32'h4);
      $display("test reset done");
      pm.send(16'hb5a3, 1'b0);
      rd(A_NPW, npw(16'hb5a3, 1'b0));
      pm.send(16'h4a5c, 1'b1);
      rd(A_NPW, npw(16'h4a5c, 1'b1));
      rd(A_EXP, 32'h6);
      rd(A_EXP, 32'h4);
      $display("test pages done");
      bus(A_NPW, 1'b1, 32'hffffffff);
      bus(A_EXP, 1'b1, 32'hffffffff);
      rd(A_NPW, npw(16'h4a5c, 1'b1));
      rd(A_EXP, 32'h4);
      rd(32'h40, 32'h0);
      $display("test writes done");
      pm.levels(1'b1, 1'b1, 1'b1);
      rd(A_EXP, 32'h1d);
      pm.levels(1'b0, 1'b0, 1'b0);
      rd(A_EXP, 32'h4);
      $display("test levels done");
      fork
         pm.send(16'h0001, 1'b0);
         begin
            @(posedge clk);
            rd(A_EXP, 32'h4);
         end
      join
      rd(A_EXP, 32'h6);
      $display("test collision done");
      rd(A_IST, 32'h3);
      chk_irq(1'b0);
      bus(A_MSK, 1'b1, 32'h1);
      chk_irq(1'b1);
      bus(A_IST, 1'b1, 32'h1);
      chk_irq(1'b0);
      rd(A_IST, 32'h2);
      bus(A_MSK, 1'b1, 32'h3);
      chk_irq(1'b1);
      bus(A_IST, 1'b1, 32'h2);
      chk_irq(1'b0);
      rd(A_MSK, 32'h3);
      $display("test interrupt done");
      close_out();
   end
endmodule
`default_nettype wire

// *** verilog/annp_map.svh ***
`ifndef ANNP_MAP_SVH
`define ANNP_MAP_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define ANNP_IDX_NPW 8'h05
`define ANNP_IDX_EXP 8'h06
`define ANNP_IDX_IST 8'h08
`define ANNP_IDX_IMSK 8'h09
// ==========================================================
// Partner next-page word fields
`define ANNP_NPW_NP 15
`define ANNP_NPW_ACK 14
`define ANNP_NPW_MP 13
`define ANNP_NPW_PARTNER_COMPLY_ACK 12
`define ANNP_NPW_TOG 11
`define ANNP_NPW_CODE_HI 10
`define ANNP_NPW_RST 16'h0000
// ==========================================================
// Expansion status fields
`define ANNP_EXP_RSV_HI 15
`define ANNP_EXP_RSV_LO 5
`define ANNP_EXP_PDF 4
`define ANNP_EXP_LPNP 3
`define ANNP_EXP_NPABLE 2
`define ANNP_EXP_PAGE 1
`define ANNP_EXP_LPAN 0
// ==========================================================
// Interrupt status and mask fields
`define ANNP_INT_PAGE 0
`define ANNP_INT_PDF 1
`define ANNP_INT_W 2
`define ANNP_INT_RST 2'h0
`endif

// *** verilog/annp_pkg.sv ***
`default_nettype none
package annp_pkg;
   typedef enum logic [2:0]
   {
      REG_NPW = 3'b000,
      REG_EXP = 3'b001,
      REG_IST = 3'b010,
      REG_IMSK = 3'b011,
      REG_NONE = 3'b100
   } annp_reg_t;
endpackage
`default_nettype wire

// *** verilog/annp_status_regs.sv ***
// Operation
// R1 - Hardware loads the partner acknowledge flag from each received page.
// R2 - Software is advised not to write the partner acknowledge flag, which hardware owns.
// R3 - Bit 13 of the next-page word shows message page (1) or unformatted page (0), reset 0.
// R4 - Bits 10:0 of the next-page word hold the partner's code field, read-only, reset zero.
// R5 - Bit 12 of the next-page word tells if the partner can comply with a message, reset 0.
// R6 - Bit 11 of the next-page word is the inverse of the previous transmitted toggle value.
// R7 - Bits 15:5 of the expansion register read zero and ignore writes.
// R8 - Bit 4 of the expansion register shows a parallel detection fault, reset 0.
// R9 - Bit 3 of the expansion register shows that the partner supports next pages.
// R10 - Bit 2 of the expansion register is a constant 1: the local device can send next pages.
// R11 - Bit 1 of the expansion register is set on a received page and cleared by a read.
// R12 - Bit 0 of the expansion register shows the partner supports auto-negotiation, reset 0.
// R13 - Bit 15 of the next-page word shows that the partner wants a further next page.
// R14 - Bit 14 of the next-page word shows that the partner acknowledged the local word.
// R15 - A page arriving in the cycle of an expansion read leaves the page flag set.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "annp_map.svh"

module annp_status_regs
   import annp_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [DATA_W-1:0] hrdata,
   // Negotiation engine
   input wire logic page_rx_stb,
   input wire logic [15:0] page_rx_word,
   input wire logic tx_toggle_prev,
   input wire logic parallel_detect_fault,
   input wire logic partner_nextpage_capable,
   input wire logic partner_autoneg_capable,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Elaboration check
   if (DATA_W != 32)
   begin : g_bad_width
      $error("annp_status_regs: DATA_W must be 32");
   end

   if (`ANNP_INT_W < 2)
   begin : g_bad_int
      $error("annp_status_regs: interrupt status needs two event bits");
   end

   if (`ANNP_EXP_RSV_HI > 15 || `ANNP_NPW_NP > 15)
   begin : g_bad_field
      $error("annp_status_regs: status fields must fit sixteen bits");
   end

   // ==========================================================
   // Address decode
   function automatic annp_reg_t reg_sel(input logic [31:0] a);
      annp_reg_t r;
      r = REG_NONE;
      if (a[1:0] == 2'h0 && a[31:10] == 22'h000000)
      begin
         if (a[9:2] == `ANNP_IDX_NPW)
            r = REG_NPW;
         else if (a[9:2] == `ANNP_IDX_EXP)
            r = REG_EXP;
         else if (a[9:2] == `ANNP_IDX_IST)
            r = REG_IST;
         else if (a[9:2] == `ANNP_IDX_IMSK)
            r = REG_IMSK;
      end
      return r;
   endfunction

   logic acc_take;
   logic rd_exp;
   logic wr_pend_q;
   annp_reg_t wr_sel_q;
   logic [15:0] npw_q;
   logic pdf_q;
   logic lpnp_q;
   logic lpan_q;
   logic page_q;
   logic [`ANNP_INT_W-1:0] ist_q;
   logic [`ANNP_INT_W-1:0] imsk_q;
   logic [`ANNP_INT_W-1:0] ist_set;
   logic [15:0] exp_word;
   logic [DATA_W-1:0] rdata_d;
   logic ist_wr;

   assign acc_take = hsel & htrans[1] & hready;
   assign rd_exp = acc_take & ~hwrite & (reg_sel(haddr) == REG_EXP);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ==========================================================
   // Partner next-page word
   always_ff @(posedge clk)
   begin
      if (rst)
         npw_q <= `ANNP_NPW_RST;
      else if (page_rx_stb)
      begin
         npw_q[`ANNP_NPW_NP] <= page_rx_word[`ANNP_NPW_NP]; // R13
         npw_q[`ANNP_NPW_ACK] <= page_rx_word[`ANNP_NPW_ACK]; // R1 R14
         npw_q[`ANNP_NPW_MP] <= page_rx_word[`ANNP_NPW_MP]; // R3
         npw_q[`ANNP_NPW_PARTNER_COMPLY_ACK] <= page_rx_word[`ANNP_NPW_PARTNER_COMPLY_ACK]; // R5
         npw_q[`ANNP_NPW_TOG] <= ~tx_toggle_prev; // R6
         npw_q[`ANNP_NPW_CODE_HI:0] <= page_rx_word[`ANNP_NPW_CODE_HI:0]; // R4
      end
   end

   // ==========================================================
   // Expansion status
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pdf_q <= 1'b0;
         lpnp_q <= 1'b0;
         lpan_q <= 1'b0;
      end
      else
      begin
         pdf_q <= parallel_detect_fault; // R8
         lpnp_q <= partner_nextpage_capable; // R9
         lpan_q <= partner_autoneg_capable; // R12
      end
   end

   // Set on a page wins over clear on read
   always_ff @(posedge clk)
   begin
      if (rst)
         page_q <= 1'b0;
      else if (page_rx_stb)
         page_q <= 1'b1; // R11 R15
      else if (rd_exp)
         page_q <= 1'b0; // R11
   end

   always_comb
   begin
      exp_word = 16'h0000;
      exp_word[`ANNP_EXP_RSV_HI:`ANNP_EXP_RSV_LO] = 11'h000; // R7
      exp_word[`ANNP_EXP_PDF] = pdf_q;
      exp_word[`ANNP_EXP_LPNP] = lpnp_q;
      exp_word[`ANNP_EXP_NPABLE] = 1'b1; // R10
      exp_word[`ANNP_EXP_PAGE] = page_q;
      exp_word[`ANNP_EXP_LPAN] = lpan_q;
   end

   // ==========================================================
   // Bus data phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_pend_q <= 1'b0;
         wr_sel_q <= REG_NONE;
      end
      else
      begin
         wr_pend_q <= acc_take & hwrite;
         wr_sel_q <= reg_sel(haddr);
      end
   end

   // Read data is sampled at the address phase edge
   always_comb
   begin
      rdata_d = '0;
      unique case (reg_sel(haddr))
         REG_NPW:
            rdata_d[15:0] = npw_q;
         REG_EXP:
            rdata_d[15:0] = exp_word;
         REG_IST:
            rdata_d[`ANNP_INT_W-1:0] = ist_q;
         REG_IMSK:
            rdata_d[`ANNP_INT_W-1:0] = imsk_q;
         REG_NONE:
            rdata_d = '0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         hrdata <= '0;
      else if (acc_take & ~hwrite)
         hrdata <= rdata_d;
   end

   // ==========================================================
   // Interrupts
   assign ist_set[`ANNP_INT_PAGE] = page_rx_stb;
   assign ist_set[`ANNP_INT_PDF] = parallel_detect_fault & ~pdf_q;
   assign ist_wr = wr_pend_q & (wr_sel_q == REG_IST);

   always_ff @(posedge clk)
   begin
      if (rst)
         ist_q <= `ANNP_INT_RST;
      else if (ist_wr)
         ist_q <= (ist_q & ~hwdata[`ANNP_INT_W-1:0]) | ist_set;
      else
         ist_q <= ist_q | ist_set;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         imsk_q <= `ANNP_INT_RST;
      else if (wr_pend_q & (wr_sel_q == REG_IMSK))
         imsk_q <= hwdata[`ANNP_INT_W-1:0];
   end

   assign irq = |(ist_q & imsk_q);

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_ack_capture: assert property (page_rx_stb |=> npw_q[14] == $past(page_rx_word[14])) // R1 R14
      else $error("ack flag not loaded from page");
   a_next_req: assert property (page_rx_stb |=> npw_q[15] == $past(page_rx_word[15])) // R13
      else $error("next page request not loaded");
   a_msg_page: assert property (page_rx_stb |=> npw_q[13] == $past(page_rx_word[13])) // R3
      else $error("message page flag wrong");
   a_comply_flag: assert property (page_rx_stb |=> npw_q[12] == $past(page_rx_word[12])) // R5
      else $error("comply flag wrong");
   a_toggle_inverse: assert property (page_rx_stb |=> npw_q[11] != $past(tx_toggle_prev)) // R6
      else $error("toggle not inverted");
   a_code_field: assert property (page_rx_stb |=> npw_q[10:0] == $past(page_rx_word[10:0])) // R4
      else $error("code field wrong");
   a_word_hold: assert property (!page_rx_stb |=> $stable(npw_q)) // R4
      else $error("next page word changed without page");
   a_exp_read: assert property (rd_exp |=> hrdata[15:5] == 11'h000 && hrdata[2]) // R7 R10
      else $error("expansion reserved or fixed bits wrong");
   a_pdf_follow: assert property (1'b1 |=> exp_word[4] == $past(parallel_detect_fault)) // R8
      else $error("fault bit does not follow");
   a_partner_able: assert property (##1 lpnp_q == $past(partner_nextpage_capable) // R9 R12
      && lpan_q == $past(partner_autoneg_capable))
      else $error("partner ability bits wrong");
   a_page_clear: assert property (rd_exp && !page_rx_stb // R11
      |=> !page_q ##0 hrdata[1] == $past(page_q))
      else $error("page flag not cleared on read");
   a_page_keep: assert property (page_rx_stb |=> page_q [*1] ##0 ist_q[0]) // R15
      else $error("page event lost");
   a_page_set: assert property (page_rx_stb |=> exp_word[1]) // R11
      else $error("page flag not set");
   a_page_hold: assert property (!page_rx_stb && !rd_exp |=> page_q == $past(page_q)) // R11
      else $error("page flag changed without cause");
   a_npw_nowrite: assert property (wr_pend_q && wr_sel_q == REG_NPW && !page_rx_stb // R4
      |=> $stable(npw_q))
      else $error("next page word took a write");
   a_exp_nowrite: assert property (wr_pend_q && wr_sel_q == REG_EXP && !page_rx_stb // R7
      && !rd_exp |=> page_q == $past(page_q))
      else $error("expansion register took a write");

   // ==========================================================
   // Bus and interrupt assertions
   a_rdata_hold: assert property (!(acc_take && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   a_npw_read: assert property (acc_take && !hwrite && reg_sel(haddr) == REG_NPW // R4
      |=> hrdata[15:0] == $past(npw_q) && hrdata[31:16] == 16'h0000)
      else $error("next page word read wrong");
   a_exp_word: assert property (rd_exp // R7 R11
      |=> hrdata[15:0] == $past(exp_word) && hrdata[31:16] == 16'h0000)
      else $error("expansion read wrong");
   a_fault_event: assert property (parallel_detect_fault && !pdf_q |=> ist_q[1]) // R8
      else $error("fault event lost");
   a_int_clear: assert property (ist_wr && hwdata[0] && !page_rx_stb |=> !ist_q[0])
      else $error("page status not cleared");
   a_int_keep: assert property (ist_q[1] && !(ist_wr && hwdata[1]) |=> ist_q[1])
      else $error("fault status lost");
   a_irq_masked: assert property (imsk_q == 2'h0 |-> !irq)
      else $error("interrupt raised while masked");
   a_mask_write: assert property (wr_pend_q && wr_sel_q == REG_IMSK
      |=> imsk_q == $past(hwdata[1:0]))
      else $error("mask write lost");
   a_imsk_hold: assert property (!(wr_pend_q && wr_sel_q == REG_IMSK) |=> $stable(imsk_q))
      else $error("mask changed without a write");

endmodule

`default_nettype wire
